// file: hdl/cgs_serial_slave.sv
// serial configuration target: two-wire bus engine for control bytes
// Contract
// - all reachable register bytes return to defaults at power-up
// - block transfers walk bytes upward, msb first, may stop per byte
// - block read: device acknowledges the command byte before repeated start
// - block read: device sends nonzero count at most 7, then data
// - block write: low seven command bits give first register index
// - command byte zero acts as plain block transfer from index zero
// - block write: device acknowledges every byte; stop ends transfer
// - byte read: repeated start after command, device then sends data
// - command msb one selects single-byte access
// - command msb zero selects block access, next byte is count
// - byte-mode transfers always name a register index
// - address-select latched at power-up picks 1101001 or 1101010
// - logic stays disabled until power-good first sampled high
// - logic disabled while in power-down
`timescale 1ns/1ps
`default_nettype none
module cgs_serial_slave import cgs_pkg::*; (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic                   address_select_pin,
  input  wire logic                   power_good_powerdown_pin,
  output logic [REG_COUNT*8-1:0]      cfg_bytes
);
  cgs_state_e       state_reg;
  cgs_phase_e       phase_reg;
  logic             scl_prev_reg;
  logic             sda_prev_reg;
  logic             pg_seen_reg;
  logic             rw_reg;
  logic             mack_reg;
  logic [6:0]       dev_addr_reg;
  logic [7:0]       rx_reg;
  logic [7:0]       tx_reg;
  logic [3:0]       bit_reg;
  logic [IDX_W-1:0] idx_reg;

  logic       enabled;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_full;
  logic       rx_done;
  logic       addr_hit;
  logic       load_tx;
  logic       send_count;
  logic [7:0] tx_byte;

  cgs_reg_if rif ();

  function automatic logic [IDX_W-1:0] idx_inc(input logic [IDX_W-1:0] v);
    return v + IDX_W'(1);
  endfunction

  // disabled before first power-good and again in power-down
  assign enabled    = pg_seen_reg & power_good_powerdown_pin;

  // bus event decode from the previous pin samples
  assign scl_rise   = scl_in & ~scl_prev_reg;
  assign scl_fall   = ~scl_in & scl_prev_reg;
  assign start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign stop_cond  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
  assign byte_full  = bit_reg == BITS_PER_BYTE;
  assign rx_done    = scl_fall & byte_full & (state_reg == ST_RX);
  assign addr_hit   = rx_reg[7:1] == dev_addr_reg;

  // next transmit byte: block read opens with its count
  assign load_tx    = scl_fall & (((state_reg == ST_ACK) & rw_reg)
                    | ((state_reg == ST_MACK) & mack_reg));
  assign send_count = phase_reg == PH_COUNT;
  assign tx_byte    = send_count ? BLOCK_RD_COUNT : rif.rd_data;

  // register access; only data-phase bytes are stored
  assign rif.idx     = idx_reg;
  assign rif.wr_data = rx_reg;
  assign rif.wr_en   = rx_done & (phase_reg == PH_DATA);

  // open drain: only ever pull low, and never while disabled
  assign sda_out = 1'b0;
  assign sda_oe  = enabled & ((state_reg == ST_ACK)
                 | ((state_reg == ST_TX) & ~tx_reg[7]));

  cgs_regfile u_regs (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .bus       (rif.store),
    .cfg_bytes (cfg_bytes)
  );

  // latch the target address when power-good first reads high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pg_seen_reg  <= 1'b0;
      dev_addr_reg <= ADDR_SEL1;
    end else if (clk_en && power_good_powerdown_pin && !pg_seen_reg) begin
      pg_seen_reg  <= 1'b1;
      dev_addr_reg <= address_select_pin ? ADDR_SEL1 : ADDR_SEL0;
    end
  end

  // byte engine; bits are sampled on scl rise and driven on scl fall
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      rw_reg       <= 1'b0;
      mack_reg     <= 1'b0;
      rx_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      bit_reg      <= 4'h0;
    end else if (clk_en) begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
      if (!enabled) begin
        state_reg <= ST_IDLE;
      end else if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_reg   <= 4'h0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_ADDR, ST_RX: begin
            if (scl_rise && !byte_full) begin
              rx_reg  <= {rx_reg[6:0], sda_in};
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && byte_full) begin
              bit_reg <= 4'h0;
              // every received byte is acknowledged once addressed
              if (state_reg == ST_RX || addr_hit) begin
                state_reg <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
              if (state_reg == ST_ADDR) begin
                rw_reg <= rx_reg[0];
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                tx_reg    <= tx_byte;
                bit_reg   <= 4'h0;
                state_reg <= ST_TX;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && byte_full) begin
              bit_reg   <= 4'h0;
              state_reg <= ST_MACK;
            end else if (scl_fall) begin
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_in;
            end else if (scl_fall) begin
              // a not-acknowledge ends the read; wait for stop
              if (mack_reg) begin
                tx_reg    <= tx_byte;
                state_reg <= ST_TX;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // transfer phase and register index; repeated start keeps both
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= PH_CMD;
      idx_reg   <= '0;
    end else if (clk_en) begin
      if (!enabled || stop_cond) begin
        phase_reg <= PH_CMD;
      end else if (rx_done) begin
        case (phase_reg)
          PH_CMD: begin
            idx_reg   <= rx_reg[6:0];
            phase_reg <= rx_reg[CMD_MODE_BIT] ? PH_DATA : PH_COUNT;
          end
          // count is not enforced; the controller keeps it in range
          PH_COUNT: phase_reg <= PH_DATA;
          PH_DATA:  idx_reg   <= idx_inc(idx_reg);
          default:  phase_reg <= PH_CMD;
        endcase
      end else if (load_tx) begin
        if (send_count) begin
          phase_reg <= PH_DATA;
        end else begin
          idx_reg <= idx_inc(idx_reg);
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_cmd_acked: assert property (
    clk_en && enabled && rx_done && phase_reg == PH_CMD |=> state_reg == ST_ACK)
    else $error("command byte not acknowledged");
  a_count_first: assert property (
    clk_en && enabled && load_tx && send_count
    |=> tx_reg == BLOCK_RD_COUNT && phase_reg == PH_DATA)
    else $error("block read did not open with its count");
  a_cmd_index: assert property (
    clk_en && enabled && rx_done && phase_reg == PH_CMD |=> idx_reg == $past(rx_reg[6:0]))
    else $error("command index not taken");
  a_mode_decode: assert property (
    clk_en && enabled && rx_done && phase_reg == PH_CMD
    |=> phase_reg == ($past(rx_reg[7]) ? PH_DATA : PH_COUNT))
    else $error("command mode bit decoded wrongly");
  a_write_acked: assert property (
    clk_en && enabled && rx_done && phase_reg == PH_DATA |-> rif.wr_en ##1 state_reg == ST_ACK)
    else $error("data byte not stored and acknowledged");
  a_index_step: assert property (
    clk_en && enabled && load_tx && !send_count |=> idx_reg == idx_inc($past(idx_reg)))
    else $error("index did not advance after read byte");
  a_addr_latch: assert property (
    clk_en && power_good_powerdown_pin && !pg_seen_reg
    |=> dev_addr_reg == ($past(address_select_pin) ? ADDR_SEL1 : ADDR_SEL0))
    else $error("target address latched wrongly");
  a_early_quiet: assert property (
    !pg_seen_reg |-> !sda_oe && state_reg == ST_IDLE)
    else $error("bus driven before power-good");
  a_powerdown_idle: assert property (
    clk_en && !enabled |=> state_reg == ST_IDLE && phase_reg == PH_CMD)
    else $error("engine active in power-down");
  a_tx_release: assert property (
    clk_en && enabled && state_reg == ST_TX && scl_fall && byte_full
    |=> state_reg == ST_MACK && !sda_oe)
    else $error("data line not released for master acknowledge");

  c_block_count: cover property (load_tx && send_count);
  c_byte_write:  cover property (rif.wr_en ##[1:40] stop_cond);
  c_master_nack: cover property (state_reg == ST_MACK && scl_fall && !mack_reg);
  c_rep_start:   cover property (phase_reg != PH_CMD && start_cond);
endmodule
`default_nettype wire

// file: hdl/cgs_pkg.sv
// constants and types shared by the serial configuration target
package cgs_pkg;
  localparam int          REG_COUNT      = 8;
  localparam int          SEL_W          = 3;
  localparam int          IDX_W          = 7;
  localparam logic [6:0]  ADDR_SEL0      = 7'h69;
  localparam logic [6:0]  ADDR_SEL1      = 7'h6a;
  localparam logic [7:0]  BLOCK_RD_COUNT = 8'h07;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam int          CMD_MODE_BIT   = 7;
  // byte 0 in the low lane
  localparam logic [REG_COUNT*8-1:0] REG_DEFAULTS =
    {8'h00, 8'h00, 8'h00, 8'hf8, 8'hff, 8'h29, 8'hf0, 8'hff};

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} cgs_state_e;
  typedef enum logic [1:0] {PH_CMD, PH_COUNT, PH_DATA} cgs_phase_e;
endpackage

// file: hdl/cgs_reg_if.sv
// register access carrier between bus engine and register store
`timescale 1ns/1ps
`default_nettype none
interface cgs_reg_if;
  import cgs_pkg::*;
  logic             wr_en;
  logic [IDX_W-1:0] idx;
  logic [7:0]       wr_data;
  logic [7:0]       rd_data;
  modport ctrl  (output wr_en, output idx, output wr_data, input rd_data);
  modport store (input wr_en, input idx, input wr_data, output rd_data);
endinterface
`default_nettype wire

// file: hdl/cgs_regfile.sv
// control register byte store with power-up defaults
`timescale 1ns/1ps
`default_nettype none
module cgs_regfile import cgs_pkg::*; (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  cgs_reg_if.store                    bus,
  output logic [REG_COUNT*8-1:0]      cfg_bytes
);
  logic [7:0] mem_reg [REG_COUNT];
  logic       in_range;
  logic [SEL_W-1:0] sel;

  // indexes past the store read zero and drop writes
  assign in_range    = bus.idx < IDX_W'(REG_COUNT);
  assign sel         = bus.idx[SEL_W-1:0];
  assign bus.rd_data = in_range ? mem_reg[sel] : 8'h00;

  // reset is the power-up event
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_reg[i] <= REG_DEFAULTS[i*8 +: 8];
      end
    end else if (clk_en && bus.wr_en && in_range) begin
      mem_reg[sel] <= bus.wr_data;
    end
  end

  for (genvar g = 0; g < REG_COUNT; g++) begin : g_out
    assign cfg_bytes[g*8 +: 8] = mem_reg[g];
  end

  a_reset_defaults: assert property (@(posedge ref_clk)
    $fell(reset) |-> cfg_bytes == REG_DEFAULTS)
    else $error("register bytes not at defaults after power-up");
endmodule
`default_nettype wire

// file: verif/cgs_host_model.sv
// bus controller model driving the two-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module cgs_host_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // four ref_clk cycles per tick; scl is high for one tick and low for two, twice what the target needs
  localparam int HALF = 4;
  // bus idle: clock high, data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(negedge ref_clk);
  endtask
  // data moves only while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
    tick();
  endtask
  // works from idle and as a repeated start mid-frame
  task automatic start();
    sda_pull = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_pull = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_pull = 1'b0;
    tick();
  endtask
  // whole bytes only, msb first, ack read in the ninth slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // caller asks for ack on all bytes but the last
  task automatic recv(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~give_ack, r);
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the serial configuration target
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
  import cgs_pkg::*;
  logic                   ref_clk = 1'b0;
  logic                   reset = 1'b1;
  logic                   clk_en = 1'b1;
  logic                   address_select_pin = 1'b1;
  logic                   power_good_powerdown_pin = 1'b0;
  logic                   sda_out;
  logic                   sda_oe;
  logic                   scl;
  logic                   sda_pull;
  logic [REG_COUNT*8-1:0] cfg_bytes;
  int                     miscompares = 0;
  int                     n_checks = 0;
  logic                   ack;
  logic [7:0]             rx;
  // open drain with pull-up: low if either side pulls
  wire logic              sda = ~(sda_pull | (sda_oe & ~sda_out));

  always #5 ref_clk = ~ref_clk;

  cgs_serial_slave DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .power_good_powerdown_pin(power_good_powerdown_pin), .cfg_bytes(cfg_bytes));
  cgs_host_model host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  task automatic addr(input logic [6:0] a, input logic rw, input logic exp);
    host.start();
    host.send({a, rw}, ack);
    `CHK(ack, exp)
  endtask
  task automatic wr(input logic [7:0] d);
    host.send(d, ack);
    `CHK(ack, 1'b1)
  endtask
  task automatic rd(input logic [7:0] exp, input logic give_ack);
    host.recv(give_ack, rx);
    `CHK(rx, exp)
  endtask
  task automatic set_pg(input logic v);
    power_good_powerdown_pin = v;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic t_power_up();
    `CHK(cfg_bytes, REG_DEFAULTS)
    addr(ADDR_SEL1, 1'b0, 1'b0);
    host.stop();
    set_pg(1'b1);
    $display("test power_up done");
  endtask
  task automatic t_byte_rw();
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h83);
    wr(8'ha5);
    host.stop();
    `CHK(cfg_bytes[31:24], 8'ha5)
    `CHK(cfg_bytes[39:32], REG_DEFAULTS[39:32])
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h83);
    addr(ADDR_SEL1, 1'b1, 1'b1);
    rd(8'ha5, 1'b0);
    host.stop();
    // index past the store: the write is dropped and the read gives zero
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h88);
    wr(8'h77);
    host.stop();
    `CHK(cfg_bytes[7:0], REG_DEFAULTS[7:0])
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h88);
    addr(ADDR_SEL1, 1'b1, 1'b1);
    rd(8'h00, 1'b0);
    host.stop();
    $display("test byte_rw done");
  endtask
  task automatic t_block_write();
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h00);
    wr(8'h02);
    wr(8'h11);
    wr(8'h22);
    host.stop();
    `CHK(cfg_bytes[7:0], 8'h11)
    `CHK(cfg_bytes[15:8], 8'h22)
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h06);
    wr(8'h02);
    wr(8'h5a);
    wr(8'h6b);
    host.stop();
    `CHK(cfg_bytes[47:40], REG_DEFAULTS[47:40])
    `CHK(cfg_bytes[55:48], 8'h5a)
    `CHK(cfg_bytes[63:56], 8'h6b)
    $display("test block_write done");
  endtask
  task automatic t_block_read();
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h00);
    addr(ADDR_SEL1, 1'b1, 1'b1);
    rd(BLOCK_RD_COUNT, 1'b1);
    rd(8'h11, 1'b1);
    rd(8'h22, 1'b1);
    rd(REG_DEFAULTS[23:16], 1'b0);
    host.stop();
    addr(ADDR_SEL0, 1'b0, 1'b0);
    host.stop();
    $display("test block_read done");
  endtask
  task automatic t_power_down();
    set_pg(1'b0);
    addr(ADDR_SEL1, 1'b0, 1'b0);
    host.stop();
    set_pg(1'b1);
    // frozen engine neither answers nor stores a whole write
    clk_en = 1'b0;
    addr(ADDR_SEL1, 1'b0, 1'b0);
    host.send(8'h85, ack);
    `CHK(ack, 1'b0)
    host.send(8'h3c, ack);
    `CHK(ack, 1'b0)
    host.stop();
    clk_en = 1'b1;
    @(negedge ref_clk);
    `CHK(cfg_bytes[47:40], REG_DEFAULTS[47:40])
    addr(ADDR_SEL1, 1'b0, 1'b1);
    wr(8'h85);
    wr(8'hc3);
    host.stop();
    `CHK(cfg_bytes[47:40], 8'hc3)
    $display("test power_down done");
  endtask
  // second power-up with the select pin low moves the address
  task automatic t_second_reset();
    reset = 1'b1;
    power_good_powerdown_pin = 1'b0;
    address_select_pin = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    `CHK(cfg_bytes, REG_DEFAULTS)
    set_pg(1'b1);
    addr(ADDR_SEL0, 1'b0, 1'b1);
    host.stop();
    addr(ADDR_SEL1, 1'b0, 1'b0);
    host.stop();
    $display("test second_reset done");
  endtask

  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_power_up();
    t_byte_rw();
    t_block_write();
    t_block_read();
    t_power_down();
    t_second_reset();
    report_and_stop();
  end
  // hang guard: a run this long counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
